// ---- core/rfci_consts.svh ----
// Offsets, field positions, reset values and command codes of the channel
`ifndef RFCI_CONSTS_SVH
`define RFCI_CONSTS_SVH
// Register byte offsets
`define RFCI_CTRL_OFS 8'h00
`define RFCI_CMD_OFS 8'h04
`define RFCI_TOUT_OFS 8'h08
`define RFCI_LEN_OFS 8'h0c
`define RFCI_STAT_OFS 8'h10
`define RFCI_RESP_OFS 8'h14
`define RFCI_FIFO_OFS 8'h18
`define RFCI_PRES_OFS 8'h1c
// Control field positions and register reset values
`define RFCI_CTRL_MODE_LSB 0
`define RFCI_CTRL_SIZE_LSB 4
`define RFCI_CTRL_MAN_BIT 8
`define RFCI_CTRL_PROT_LSB 9
`define RFCI_CTRL_RST 32'h0000_0011
`define RFCI_TOUT_RST 32'h0000_ffff
// Command codes
`define RFCI_C_IDLE 8'h00
`define RFCI_C_INV 8'h01
`define RFCI_C_READ 8'h02
`define RFCI_C_WRITE 8'h04
`define RFCI_C_WRVER 8'h08
`define RFCI_C_CSTART 8'h10
`define RFCI_C_BREAD 8'h11
`define RFCI_C_BDEL 8'h12
`define RFCI_C_CSTOP 8'h13
`define RFCI_C_HID 8'h50
`define RFCI_C_TINFO 8'h70
`define RFCI_C_PWD 8'h60
`define RFCI_C_PROT 8'h61
`define RFCI_C_RESET 8'h80
// Limits
`define RFCI_MAX_BYTES 16'h0080
`define RFCI_NO_PROT 2'h3
`endif

// ---- core/rfci_pkg.sv ----
// Types shared by the channel command interface
package rfci_pkg;
  typedef enum logic [2:0] {
    RFCI_HF_COMPACT = 3'h0,
    RFCI_HF_EXT = 3'h1,
    RFCI_HF_BUS = 3'h2,
    RFCI_UHF_COMPACT = 3'h3,
    RFCI_UHF_EXT = 3'h4
  } rfci_mode_type;
  typedef enum logic [1:0] {
    RFCI_S_IDLE = 2'h0,
    RFCI_S_ISSUE = 2'h1,
    RFCI_S_WAIT = 2'h2
  } rfci_state_type;
  typedef struct packed {
    logic [7:0] cmd;
    logic [4:0] addr;
    logic all_heads;
    logic [7:0] frag_idx;
    logic last_frag;
  } rfci_head_req_type;
endpackage

// ---- core/rfci_channel.sv ----
// RFID channel command interface: result FIFO and channel top with APB slave
//
// Behaviour
// - At most 128 bytes per cycle, else fragments
// - Fragment size 8, 16, 32, 64 or 128
// - Auto detect adopts first requesting protocol
// - Other protocols get read access only
// - Manual protocol skips detection, stays fixed
// - One of five data interface modes
// - Compact modes: up to 128 bytes unfragmented
// - Extended modes add fragmented multi transfers
// - Extended modes bound command time by timeout
// - HF continuous repeats command, results FIFO
// - Bus mode: 32 heads, one busy
// - Bus mode reports presence per head
// - Continuous bus: all heads, ring buffer
// - UHF presence sensing: power reader, repeat, FIFO
// - Distinct command codes for all functions
// - Loop counter repeat done in two cycles
// - Successful command code echoed in response
//
// Chosen here: the placing of the registers and register access over APB.
`include "rfci_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Result FIFO
// ************************************************************
module rfci_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // Honest flags straight from the count
  // Count is one bit wider than the pointers so full and empty differ
  assign in_ready = (cnt_ff != (AW+1)'(DEPTH)) && !flush;
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rp_ff];
  assign level = cnt_ff;
  // Storage written only, never reset
  always_ff @(posedge pclk)
  begin
    if (push)
      mem_ff[wp_ff] <= in_data;
  end
  // Pointers and count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else if (flush)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wp_ff <= push ? AW'(wp_ff + 1'b1) : wp_ff;
      rp_ff <= pop ? AW'(rp_ff + 1'b1) : rp_ff;
      cnt_ff <= (AW+1)'(cnt_ff + push - pop);
    end
  end
endmodule

// ************************************************************
// Channel top
// ************************************************************
module rfci_channel #(
  parameter int FIFO_DEPTH = 32,
  parameter int HEADS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] conn_req,
  input wire logic startup_done,
  input wire logic [1:0] fb_wr_proto,
  output logic fb_wr_permit,
  output logic [1:0] proto_ff,
  output rfci_pkg::rfci_head_req_type head_req,
  output logic head_req_valid,
  input wire logic head_done,
  input wire logic head_ok,
  input wire logic head_data_valid,
  output logic head_data_ready,
  input wire logic [31:0] head_data,
  input wire logic [HEADS-1:0] tag_present,
  output logic reader_on_ff
);
  // ************************************************************
  // Registers and state
  // ************************************************************
  logic [31:0] ctrl_ff;
  logic [31:0] cmd_ff;
  logic [31:0] tout_ff;
  logic [15:0] len_ff;
  logic [7:0] resp_ff;
  logic [7:0] loop_seen_ff;
  logic err_ff;
  logic cont_ff;
  logic [31:0] tcnt_ff;
  logic [7:0] frag_ff;
  logic [7:0] run_cmd_ff;
  rfci_pkg::rfci_head_req_type req_ff;
  rfci_pkg::rfci_state_type st_ff;
  rfci_pkg::rfci_state_type nxt_st;
  logic [$clog2(FIFO_DEPTH):0] flevel;
  logic f_valid;
  logic [31:0] f_data;

  // Bytes per fragment from the size code
  function automatic logic [15:0] frag_bytes(input logic [2:0] code);
    logic [15:0] b;
    b = 16'h0008;
    if (code < 3'h5)
      b = 16'(16'h0008 << code);
    else
      b = `RFCI_MAX_BYTES;
    return b;
  endfunction

  // ************************************************************
  // Decode
  // ************************************************************
  wire [2:0] mode = ctrl_ff[`RFCI_CTRL_MODE_LSB +: 3];
  wire [2:0] size_code = ctrl_ff[`RFCI_CTRL_SIZE_LSB +: 3];
  wire manual = ctrl_ff[`RFCI_CTRL_MAN_BIT];
  wire [1:0] man_prot = ctrl_ff[`RFCI_CTRL_PROT_LSB +: 2];
  wire [7:0] cmd_code = cmd_ff[7:0];
  wire [7:0] loop_cnt = cmd_ff[15:8];
  wire [4:0] cmd_addr = cmd_ff[20:16];
  wire ext_mode = (mode == rfci_pkg::RFCI_HF_EXT) ||
    (mode == rfci_pkg::RFCI_UHF_EXT);
  wire bus_mode = (mode == rfci_pkg::RFCI_HF_BUS);
  wire uhf_ext = (mode == rfci_pkg::RFCI_UHF_EXT);
  wire mode_ok = (mode <= rfci_pkg::RFCI_UHF_EXT);
  wire [15:0] fbytes = frag_bytes(size_code);
  // Fragments needed; compact modes send one block only
  wire [15:0] nfrag_w = 16'((len_ff + fbytes - 16'h0001) / fbytes);
  wire [7:0] nfrag = (nfrag_w == 16'h0000) ? 8'h01 : nfrag_w[7:0];
  wire len_bad = !ext_mode && (len_ff > `RFCI_MAX_BYTES);
  wire cont_cmd = (cmd_code == `RFCI_C_CSTART);
  wire cont_ok = ext_mode || bus_mode;

  // ************************************************************
  // APB access
  // ************************************************************
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_ctrl = (paddr == `RFCI_CTRL_OFS);
  wire hit_cmd = (paddr == `RFCI_CMD_OFS);
  wire hit_tout = (paddr == `RFCI_TOUT_OFS);
  wire hit_len = (paddr == `RFCI_LEN_OFS);
  wire hit_stat = (paddr == `RFCI_STAT_OFS);
  wire hit_resp = (paddr == `RFCI_RESP_OFS);
  wire hit_fifo = (paddr == `RFCI_FIFO_OFS);
  wire hit_pres = (paddr == `RFCI_PRES_OFS);
  wire mapped = hit_ctrl || hit_cmd || hit_tout || hit_len ||
    hit_stat || hit_resp || hit_fifo || hit_pres;
  // Zero wait states; unmapped answers with an error
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  wire busy = (st_ff != rfci_pkg::RFCI_S_IDLE);
  wire [31:0] stat_w = {9'h000, 2'(flevel >> 5), flevel[4:0],
    nfrag, cont_ff, err_ff, busy, len_bad, proto_ff, 1'b0, mode_ok};
  wire [31:0] pres_w = 32'(tag_present & {HEADS{bus_mode}});
  // Read mux; reading the data word pops the FIFO
  assign prdata = hit_ctrl ? ctrl_ff :
    hit_cmd ? cmd_ff :
    hit_tout ? tout_ff :
    hit_len ? {16'h0000, len_ff} :
    hit_stat ? stat_w :
    hit_resp ? {24'h000000, resp_ff} :
    hit_fifo ? (f_valid ? f_data : 32'h0000_0000) :
    hit_pres ? pres_w : 32'h0000_0000;
  wire f_pop = rd && hit_fifo;

  // Software-written registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= `RFCI_CTRL_RST;
      cmd_ff <= 32'h0000_0000;
      tout_ff <= `RFCI_TOUT_RST;
      len_ff <= 16'h0000;
    end
    else if (wr)
    begin
      ctrl_ff <= hit_ctrl ? pwdata : ctrl_ff;
      cmd_ff <= hit_cmd ? pwdata : cmd_ff;
      tout_ff <= hit_tout ? pwdata : tout_ff;
      len_ff <= hit_len ? pwdata[15:0] : len_ff;
    end
  end

  // ************************************************************
  // Protocol adoption
  // ************************************************************
  // Lowest-numbered request wins a tie in the same cycle
  wire [1:0] first_req = conn_req[0] ? 2'h0 :
    conn_req[1] ? 2'h1 : 2'h2;
  wire snoop = !manual && !startup_done &&
    (proto_ff == `RFCI_NO_PROT);
  assign fb_wr_permit = (fb_wr_proto == proto_ff) &&
    (proto_ff != `RFCI_NO_PROT);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      proto_ff <= `RFCI_NO_PROT;
    else if (manual)
      proto_ff <= man_prot;
    else if (snoop && (conn_req != 3'h0))
      proto_ff <= first_req;
  end

  // ************************************************************
  // Command sequencer
  // ************************************************************
  wire new_loop = (loop_cnt != loop_seen_ff);
  wire head_cmd = (cmd_code != `RFCI_C_IDLE) && (cmd_code != `RFCI_C_BREAD) &&
    (cmd_code != `RFCI_C_BDEL) && (cmd_code != `RFCI_C_CSTOP) &&
    (cmd_code != `RFCI_C_RESET);
  // A new code, or same code with a bumped loop count, starts a run
  wire start = (st_ff == rfci_pkg::RFCI_S_IDLE) && head_cmd && mode_ok &&
    !len_bad && ((cmd_code != run_cmd_ff) || new_loop ||
    (cont_ff && cont_ok));
  wire tout_hit = ext_mode && (tcnt_ff >= tout_ff);
  wire last = (frag_ff == nfrag - 8'h01) || !ext_mode;
  wire fin = (st_ff == rfci_pkg::RFCI_S_WAIT) && ((head_done && last) ||
    tout_hit);
  wire flush = (cmd_code == `RFCI_C_BDEL) || (cmd_code == `RFCI_C_RESET);

  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      rfci_pkg::RFCI_S_IDLE:
        nxt_st = start ? rfci_pkg::RFCI_S_ISSUE : rfci_pkg::RFCI_S_IDLE;
      rfci_pkg::RFCI_S_ISSUE:
        nxt_st = rfci_pkg::RFCI_S_WAIT;
      rfci_pkg::RFCI_S_WAIT:
        if (fin)
          nxt_st = rfci_pkg::RFCI_S_IDLE;
        else if (head_done)
          nxt_st = rfci_pkg::RFCI_S_ISSUE; // Next fragment
      default:
        nxt_st = rfci_pkg::RFCI_S_IDLE;
    endcase
  end

  // State, fragment index and timeout counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= rfci_pkg::RFCI_S_IDLE;
      frag_ff <= 8'h00;
      tcnt_ff <= 32'h0000_0000;
    end
    else
    begin
      st_ff <= (cmd_code == `RFCI_C_RESET) ? rfci_pkg::RFCI_S_IDLE : nxt_st;
      frag_ff <= start ? 8'h00 :
        (head_done && busy) ? 8'(frag_ff + 8'h01) : frag_ff;
      tcnt_ff <= (st_ff == rfci_pkg::RFCI_S_WAIT) ?
        32'(tcnt_ff + 32'h1) : 32'h0000_0000;
    end
  end

  // Run bookkeeping, result code and loop acceptance
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_cmd_ff <= `RFCI_C_IDLE;
      loop_seen_ff <= 8'h00;
      resp_ff <= `RFCI_C_IDLE;
      err_ff <= 1'b0;
      cont_ff <= 1'b0;
    end
    else
    begin
      // Clearing to idle arms a reissue of the same code
      run_cmd_ff <= start ? cmd_code :
        (cmd_code == `RFCI_C_IDLE) ? `RFCI_C_IDLE : run_cmd_ff;
      loop_seen_ff <= start ? loop_cnt : loop_seen_ff;
      if (fin)
      begin
        resp_ff <= (head_ok && !tout_hit) ? run_cmd_ff : `RFCI_C_IDLE;
        err_ff <= !head_ok || tout_hit;
      end
      else if (start)
        err_ff <= 1'b0;
      cont_ff <= (cont_cmd && cont_ok) ? 1'b1 :
        ((cmd_code == `RFCI_C_CSTOP) || flush) ? 1'b0 : cont_ff;
    end
  end

  // Head request carrier; continuous bus runs on every head at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_ff <= '0;
    else if (nxt_st == rfci_pkg::RFCI_S_ISSUE)
    begin
      req_ff.cmd <= start ? cmd_code : run_cmd_ff;
      req_ff.addr <= bus_mode ? cmd_addr : 5'h00;
      req_ff.all_heads <= bus_mode && cont_ff;
      req_ff.frag_idx <= start ? 8'h00 : 8'(frag_ff + 8'h01);
      req_ff.last_frag <= !ext_mode || (nfrag == 8'h01) ||
        (!start && (frag_ff + 8'h02 == nfrag));
    end
  end
  assign head_req = req_ff;
  // Single outstanding request keeps one head busy at a time, every head when all_heads is set in continuous bus
  assign head_req_valid = (st_ff == rfci_pkg::RFCI_S_ISSUE);

  // UHF reader powered only while presence sensing is running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reader_on_ff <= 1'b0;
    else
      reader_on_ff <= uhf_ext && cont_ff;
  end

  // ************************************************************
  // Result buffer
  // ************************************************************
  // Full FIFO stalls the head's data stream rather than losing words
  rfci_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(flush),
    .in_valid(head_data_valid),
    .in_ready(head_data_ready),
    .in_data(head_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data),
    .level(flevel)
  );
endmodule
`default_nettype wire

// ---- verification/rfci_channel_sva.sv ----
// Port-level property checker for the channel top
`timescale 1ns/1ps
`default_nettype none
// ***
// Checker
// ***
module rfci_channel_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] conn_req,
  input wire logic startup_done,
  input wire logic [1:0] fb_wr_proto,
  input wire logic fb_wr_permit,
  input wire logic [1:0] proto_ff,
  input wire rfci_pkg::rfci_head_req_type head_req,
  input wire logic head_req_valid
);
  // Access decode and the lowest requesting protocol
  wire logic acc = psel && penable;
  wire logic ctrl_wr = acc && pwrite && paddr == 8'h00;
  wire logic bad = paddr > 8'h1c || paddr[1:0] != 2'h0;
  wire logic [1:0] low = conn_req[0] ? 2'h0 : (conn_req[1] ? 2'h1 : 2'h2);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  zero_wait_a: assert property (acc |-> pready)
    else $error("access phase without ready");
  bad_addr_a: assert property (acc && !pwrite && bad |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  good_addr_a: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access refused");
  req_pulse_a: assert property (head_req_valid |=> !head_req_valid)
    else $error("request valid longer than a cycle");
  req_hold_a: assert property ($changed(head_req) |-> ##[0:1] head_req_valid)
    else $error("head request changed without issue");
  permit_a: assert property (proto_ff != 2'h3 |-> fb_wr_permit == (fb_wr_proto == proto_ff))
    else $error("write permit wrong");
  detect_a: assert property (proto_ff == 2'h3 && !startup_done && conn_req != 3'h0 |-> ##[1:2] proto_ff != 2'h3)
    else $error("connection request not adopted");
  first_a: assert property ($past(proto_ff) == 2'h3 && proto_ff != 2'h3 && !$past(ctrl_wr) |-> proto_ff == $past(low))
    else $error("adopted protocol not the first");
  keep_a: assert property ($changed(proto_ff) && $past(proto_ff) != 2'h3 |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("adopted protocol changed");
  cover property (head_req_valid && head_req.last_frag);
  cover property (acc && pslverr);
  cover property ($changed(proto_ff));
endmodule
`default_nettype wire

// ---- verification/rfci_head_model.sv ----
// Behavioural read/write head facing the channel
`timescale 1ns/1ps
`default_nettype none
// ***
// Head model
// ***
module rfci_head_model #(
  parameter logic [31:0] BASE = 32'h0000_a500
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic head_req_valid,
  input wire logic slow,
  input wire logic ok,
  input wire logic fill,
  input wire logic head_data_ready,
  output logic head_done,
  output logic head_ok,
  output logic head_data_valid,
  output logic [31:0] head_data
);
  logic [2:0] cnt_ff;
  logic [31:0] word_ff;
  // Off-strobe values are junk so nothing leans on stale data
  assign head_ok = head_done ? ok : !ok;
  assign head_data_valid = fill;
  assign head_data = fill ? word_ff : ~word_ff;
  // One request served at a time, prompt or slow
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= 3'h0;
      head_done <= 1'b0;
      word_ff <= BASE;
    end
    else
    begin
      head_done <= cnt_ff == 3'h1;
      if (head_req_valid)
        cnt_ff <= slow ? 3'h5 : 3'h1;
      else if (cnt_ff != 3'h0)
        cnt_ff <= cnt_ff - 3'h1;
      if (fill && head_data_ready)
        word_ff <= word_ff + 32'h1;
    end
  end
endmodule
`default_nettype wire

// ---- verification/rfci_channel_tb.sv ----
// Self-checking bench for the channel command interface
`include "rfci_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
// ***
// Bench top
// ***
module rfci_channel_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, startup_done = 1'b0, slow = 1'b0, ok = 1'b1;
  logic fill = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, tag_present = 32'h0;
  logic [2:0] conn_req = 3'h0;
  logic [1:0] fb_wr_proto = 2'h0;
  logic [31:0] prdata, head_data, rd;
  logic pready, pslverr, fb_wr_permit, head_req_valid, head_done, head_ok;
  logic head_data_valid, head_data_ready, reader_on_ff, err, lastf;
  logic [1:0] proto_ff, pexp;
  logic [7:0] seen;
  logic [15:0] lfsr_ff = 16'h3cca;
  rfci_pkg::rfci_head_req_type head_req;
  int failures = 0, checked = 0, cyc = 0, cnt, lat, len, i;
  logic [7:0] codes [8] = '{`RFCI_C_INV, `RFCI_C_READ, `RFCI_C_WRITE,
    `RFCI_C_WRVER, `RFCI_C_HID, `RFCI_C_TINFO, `RFCI_C_PWD, `RFCI_C_PROT};
  rfci_channel #(.FIFO_DEPTH(32), .HEADS(32)) dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .conn_req, .startup_done, .fb_wr_proto, .fb_wr_permit, .proto_ff,
    .head_req, .head_req_valid, .head_done, .head_ok, .head_data_valid,
    .head_data_ready, .head_data, .tag_present, .reader_on_ff);
  rfci_head_model head (.pclk, .presetn, .head_req_valid, .slow, .ok,
    .fill, .head_data_ready, .head_done, .head_ok, .head_data_valid,
    .head_data);
  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic int frags(input int l, input int sz);
    return (l + (8 << sz) - 1) / (8 << sz);
  endfunction
  // Bus cycle: setup, access, answer taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issue a command, count head requests, then fetch the response
  task automatic cmd(input logic [7:0] c, input logic [7:0] lp);
    apb(1'b1, `RFCI_CMD_OFS, {16'h0, lp, c});
    cnt = 0;
    lat = 0;
    for (int k = 1; k <= 120; k++)
    begin
      @(negedge pclk);
      if (head_req_valid === 1'b1)
      begin
        if (cnt == 0) lat = k;
        if (cnt == 0) seen = head_req.cmd;
        cnt++;
        lastf = head_req.last_frag;
      end
    end
    apb(1'b0, `RFCI_RESP_OFS, 32'h0);
  endtask
  task automatic print_verdict;
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Clock, and a ceiling on run length
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      print_verdict();
    end
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `RFCI_CTRL_OFS, 32'h0);
    `CHK("ctrl", `RFCI_CTRL_RST, rd);
    apb(1'b0, `RFCI_TOUT_OFS, 32'h0);
    `CHK("tout", `RFCI_TOUT_RST, rd);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 1'b1, err);
    conn_req <= lfsr_ff[2:0] | 3'h4;
    pexp = lfsr_ff[0] ? 2'h0 : (lfsr_ff[1] ? 2'h1 : 2'h2);
    repeat (3) @(negedge pclk);
    `CHK("proto", pexp, proto_ff);
    for (i = 0; i < 3; i++)
    begin
      @(posedge pclk);
      fb_wr_proto <= 2'(i);
      @(negedge pclk);
      `CHK("permit", pexp == 2'(i), fb_wr_permit);
    end
    startup_done <= 1'b1;
    conn_req <= 3'h7;
    tag_present <= {lfsr_ff, ~lfsr_ff};
    // Presence is only reported in bus mode
    apb(1'b1, `RFCI_CTRL_OFS, 32'h12);
    apb(1'b0, `RFCI_PRES_OFS, 32'h0);
    `CHK("proto kept", pexp, proto_ff);
    `CHK("presence", {lfsr_ff, ~lfsr_ff}, rd);
    apb(1'b1, `RFCI_LEN_OFS, 32'h8);
    for (i = 0; i < 8; i++)
    begin
      lfsr_ff = lfsr_step(lfsr_ff);
      slow <= lfsr_ff[0];
      cmd(codes[i], 8'h00);
      `CHK("head cmd", codes[i], seen);
      `CHK("resp", {24'h0, codes[i]}, rd);
    end
    cmd(codes[7], 8'h01);
    `CHK("loop fast", 1'b1, lat > 0 && lat <= 2);
    `CHK("loop resp", {24'h0, codes[7]}, rd);
    cmd(codes[7], 8'h01);
    `CHK("loop same", 0, cnt);
    // Clear to idle, then set the same code again
    cmd(`RFCI_C_IDLE, 8'h01);
    cmd(codes[7], 8'h01);
    `CHK("reissue", 1, cnt);
    ok <= 1'b0;
    cmd(`RFCI_C_INV, 8'h00);
    `CHK("fail resp", 32'h0, rd);
    ok <= 1'b1;
    slow <= 1'b0;
    lfsr_ff = lfsr_step(lfsr_ff);
    len = 9 + lfsr_ff[6:0];
    apb(1'b1, `RFCI_CTRL_OFS, 32'h01);
    apb(1'b1, `RFCI_LEN_OFS, 32'(len));
    cmd(`RFCI_C_READ, 8'h00);
    `CHK("fragments", frags(len, 0), cnt);
    `CHK("last frag", 1'b1, lastf);
    apb(1'b1, `RFCI_CTRL_OFS, 32'h10);
    apb(1'b1, `RFCI_LEN_OFS, 32'd129);
    cmd(`RFCI_C_WRITE, 8'h00);
    `CHK("compact refuse", 0, cnt);
    apb(1'b1, `RFCI_LEN_OFS, 32'd128);
    cmd(`RFCI_C_INV, 8'h00);
    `CHK("compact whole", 1, cnt);
    fill <= 1'b1;
    i = 0;
    while (head_data_ready !== 1'b0 && i < 100)
    begin
      @(negedge pclk);
      i++;
    end
    `CHK("fifo full", 1'b0, head_data_ready);
    @(posedge pclk);
    fill <= 1'b0;
    for (i = 0; i < 32; i++)
    begin
      apb(1'b0, `RFCI_FIFO_OFS, 32'h0);
      `CHK("fifo word", 32'h0000_a500 + 32'(i), rd);
    end
    apb(1'b0, `RFCI_FIFO_OFS, 32'h0);
    `CHK("fifo empty", 32'h0, rd);
    print_verdict();
  end
endmodule
bind rfci_channel rfci_channel_sva chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .conn_req, .startup_done,
  .fb_wr_proto, .fb_wr_permit, .proto_ff, .head_req, .head_req_valid);
`default_nettype wire
